// file: shr_ee_model.sv
// serial eeprom loader model facing the hot reset sequencer
`default_nettype none
module shr_ee_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // load start from the sequencer
    input wire logic ee_start,
    // scenario knobs, loads shorter than 3 are not supported
    input wire logic fail_load,
    input wire logic [2:0] fail_code,
    input wire logic [3:0] retrain_mask,
    input wire logic [3:0] load_len,
    // loader answers
    output logic ee_done,
    output logic ee_error,
    output logic [2:0] ee_error_code,
    output logic ee_retrain_wr,
    output logic [3:0] ee_retrain_mask
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] step_r; // cycles into the load, zero when idle
    logic [3:0] junk_r; // moving pattern so stale fields never look valid
    // load progress and idle pattern
    always_ff @(posedge clk) begin
        junk_r <= reset ? 4'h0 : junk_r + 4'h5;
        if (reset || step_r == load_len) begin
            step_r <= 4'h0;
        end else if (ee_start || step_r != 4'h0) begin
            step_r <= step_r + 4'h1;
        end
    end
    assign ee_retrain_wr = step_r == 4'h2 && retrain_mask != 4'h0;
    assign ee_retrain_mask = ee_retrain_wr ? retrain_mask : junk_r;
    // load ends in done or error
    assign ee_done = step_r == load_len && step_r != 4'h0 && !fail_load;
    assign ee_error = step_r == load_len && step_r != 4'h0 && fail_load;
    assign ee_error_code = ee_error ? fail_code : junk_r[2:0];
endmodule
`default_nettype wire

// file: shr_pkg.sv
// hot reset sequencer types
`default_nettype none
package shr_pkg;
    // sequencer states
    typedef enum logic [2:0] {
        SHR_IDLE,
        SHR_HOLD,
        SHR_QUASI,
        SHR_EELOAD,
        SHR_HALT
    } shr_state_t;
endpackage
`default_nettype wire

// file: shr_regs.svh
// hot reset sequencer: register offsets, fields, reset values and timing
`ifndef SHR_REGS_SVH
`define SHR_REGS_SVH
// register byte offsets
`define SHR_CTL_OFS 5'h00
`define SHR_STS_OFS 5'h04
`define SHR_BRIDGE_OFS 5'h08
`define SHR_GPIO_OFS 5'h0C
`define SHR_STATE_OFS 5'h10
// switch_control_reg fields
`define SHR_CTL_HR 0
`define SHR_CTL_LDD 1
`define SHR_CTL_EED 2
`define SHR_CTL_HALT 3
// smbus_status_reg fields
`define SHR_STS_DONE 0
`define SHR_STS_ERR_LSB 1
`define SHR_STS_ERR_MSB 3
// bridge_control_reg fields
`define SHR_BRIDGE_SBR 0
// gpio reset-pin control fields
`define SHR_GPIO_OE_LSB 0
`define SHR_GPIO_OE_MSB 3
`define SHR_GPIO_VAL_LSB 4
`define SHR_GPIO_VAL_MSB 7
// reset values
`define SHR_ZERO32 32'h0000_0000
`define SHR_GPIO_OE_RST 4'h0
`define SHR_GPIO_VAL_RST 4'hF
// downstream port count
`define SHR_NPORT 4
// operating mode that loads from serial eeprom
`define SHR_MODE_EE 3'h1
// timing: figures in ms, clock in kHz
`define SHR_CLK_KHZ 50000
`define SHR_TRAIN_MS 20
`define SHR_CRS_MS 100
`endif

// file: shr_top.sv
// hot reset sequencer with avalon-mm register slave
//
// What this block does
// - upstream hot reset ordered sets start reset
// - link down starts reset unless disabled
// - software hot reset bit starts reset
// - write completes before soft reset begins
// - linked downstream ports send hot reset
// - core logic reset, smbus and phy spared
// - non-sticky fields cleared, sticky ones kept
// - training starts, sequence continues without waiting
// - training active within 20 ms
// - quasi reset answers config with retry
// - eeprom load when mode needs, not disabled
// - eeprom retrain bit retrains that port
// - load error aborts, sets halt, logs error
// - done set on success or error
// - halt holds logic in reset, smbus spared
// - smbus reads zero, writes dropped in reset
// - port reset pins undriven after fundamental reset
// - secondary bus reset bit starts that reset
// - sampled mode decides eeprom need
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`include "shr_regs.svh"
`default_nettype none
module shr_top #(
    // cycles allowed from reset clear to training
    parameter int unsigned TRAIN_CYC = `SHR_TRAIN_MS * `SHR_CLK_KHZ,
    // cycles allowed from reset clear to retry answers
    parameter int unsigned CRS_CYC = `SHR_CRS_MS * `SHR_CLK_KHZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // avalon-mm slave (slave smbus register path)
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // upstream link events
    input wire logic us_hot_reset_ts1,
    input wire logic us_dl_down,
    // downstream links
    input wire logic [`SHR_NPORT-1:0] ds_link_up,
    output logic [`SHR_NPORT-1:0] ds_hot_reset_ts1,
    output logic [`SHR_NPORT-1:0] ds_retrain,
    output logic link_train_start,
    // core reset controls
    input wire logic [2:0] switch_operating_mode,
    output logic core_reset,
    output logic stack_quasi_reset,
    output logic nonsticky_clear,
    output logic us_sec_bus_reset,
    output shr_pkg::shr_state_t seq_state,
    // configuration requests
    input wire logic cfg_req,
    output logic cfg_retry,
    // serial eeprom loader
    output logic ee_start,
    output logic ee_abort,
    input wire logic ee_done,
    input wire logic ee_error,
    input wire logic [2:0] ee_error_code,
    input wire logic ee_retrain_wr,
    input wire logic [`SHR_NPORT-1:0] ee_retrain_mask,
    // downstream port reset pins
    output logic [`SHR_NPORT-1:0] port_rst_n_o,
    output logic [`SHR_NPORT-1:0] port_rst_oe
);
    import shr_pkg::*;

    shr_state_t state_nxt; // next sequencer state
    logic [2:0] mode_r; // mode caught at fundamental reset
    logic ctl_ldd_r; // link-down trigger disable, sticky
    logic ctl_eed_r; // eeprom reload disable, sticky
    logic ctl_halt_r; // reset halt bit
    logic sw_pend_r; // soft hot reset request pulse
    logic sts_done_r; // eeprom load finished
    logic [2:0] sts_err_r; // eeprom error code
    logic [31:0] rd_mux; // read value before hold masking
    logic hr_cond; // any enabled trigger
    logic hold_now; // registers under hot reset
    logic enter_hold; // first cycle of a new hot reset
    logic acc_rd; // read taken this edge
    logic wr_ok; // write taken and not discarded
    logic pending_r; // waiting for training start
    logic [31:0] wait_cnt_r; // cycles since trigger cleared

    // address match, shared by read and write paths
    function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
        hit = (a == ofs);
    endfunction
    // does this operating mode load from eeprom
    function automatic logic needs_ee(input logic [2:0] m);
        needs_ee = (m == `SHR_MODE_EE);
    endfunction
    // disable only masks the link-down trigger
    assign hr_cond = us_hot_reset_ts1 | (us_dl_down & ~ctl_ldd_r) | sw_pend_r;
    assign hold_now = (seq_state == SHR_HOLD);
    assign enter_hold = hr_cond & ~hold_now;
    assign acc_rd = avs_read & ~avs_waitrequest;
    // writes during hot reset are dropped
    assign wr_ok = avs_write & ~avs_waitrequest & avs_byteenable[0] & ~hold_now;

    // one wait cycle per access, then accept
    always_ff @(posedge clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
        end
    end
    // read mux over the register map
    always_comb begin
        rd_mux = `SHR_ZERO32;
        if (hit(avs_address, `SHR_CTL_OFS)) begin
            rd_mux[`SHR_CTL_LDD] = ctl_ldd_r;
            rd_mux[`SHR_CTL_EED] = ctl_eed_r;
            rd_mux[`SHR_CTL_HALT] = ctl_halt_r;
        end else if (hit(avs_address, `SHR_STS_OFS)) begin
            rd_mux[`SHR_STS_DONE] = sts_done_r;
            rd_mux[`SHR_STS_ERR_MSB:`SHR_STS_ERR_LSB] = sts_err_r;
        end else if (hit(avs_address, `SHR_BRIDGE_OFS)) begin
            rd_mux[`SHR_BRIDGE_SBR] = us_sec_bus_reset;
        end else if (hit(avs_address, `SHR_GPIO_OFS)) begin
            rd_mux[`SHR_GPIO_OE_MSB:`SHR_GPIO_OE_LSB] = port_rst_oe;
            rd_mux[`SHR_GPIO_VAL_MSB:`SHR_GPIO_VAL_LSB] = port_rst_n_o;
        end else if (hit(avs_address, `SHR_STATE_OFS)) begin
            rd_mux[2:0] = seq_state;
        end
    end
    // read data latched during the wait cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            avs_readdata <= `SHR_ZERO32;
        end else if (avs_read & avs_waitrequest) begin
            // registers in hot reset read as zero
            avs_readdata <= hold_now ? `SHR_ZERO32 : rd_mux;
        end
    end
    // operating mode caught while fundamental reset is held
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_r <= switch_operating_mode;
        end
    end
    // sticky disables, untouched by hot reset
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl_ldd_r <= 1'b0;
            ctl_eed_r <= 1'b0;
        end else if (wr_ok && hit(avs_address, `SHR_CTL_OFS)) begin
            ctl_ldd_r <= avs_writedata[`SHR_CTL_LDD];
            ctl_eed_r <= avs_writedata[`SHR_CTL_EED];
        end
    end
    // soft hot reset: pulse one cycle after the write completes
    always_ff @(posedge clk) begin
        if (reset) begin
            sw_pend_r <= 1'b0;
        end else begin
            // write already completed on this edge
            sw_pend_r <= wr_ok & hit(avs_address, `SHR_CTL_OFS) & avs_writedata[`SHR_CTL_HR];
        end
    end
    // halt bit: hardware sets, software may only clear
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl_halt_r <= 1'b0;
        end else if (seq_state == SHR_EELOAD && ee_error) begin
            // load error sets halt, set wins
            ctl_halt_r <= 1'b1;
        end else if (enter_hold) begin
            ctl_halt_r <= 1'b0;
        end else if (wr_ok && hit(avs_address, `SHR_CTL_OFS) && !avs_writedata[`SHR_CTL_HALT]) begin
            ctl_halt_r <= 1'b0;
        end
    end
    // smbus status: done and error code
    always_ff @(posedge clk) begin
        if (reset) begin
            sts_done_r <= 1'b0;
            sts_err_r <= 3'h0;
        end else if (seq_state == SHR_EELOAD && (ee_done || ee_error)) begin
            // done on success or on error
            sts_done_r <= 1'b1;
            if (ee_error) begin
                sts_err_r <= ee_error_code;
            end
        end else if (enter_hold) begin
            sts_done_r <= 1'b0;
            sts_err_r <= 3'h0;
        end else if (wr_ok && hit(avs_address, `SHR_STS_OFS) && avs_writedata[`SHR_STS_DONE]) begin
            sts_done_r <= 1'b0;
        end
    end
    // upstream secondary bus reset bit, non-sticky
    always_ff @(posedge clk) begin
        if (reset) begin
            us_sec_bus_reset <= 1'b0;
        end else if (enter_hold) begin
            us_sec_bus_reset <= 1'b0;
        end else if (wr_ok && hit(avs_address, `SHR_BRIDGE_OFS)) begin
            // bit drives the bus reset out
            us_sec_bus_reset <= avs_writedata[`SHR_BRIDGE_SBR];
        end
    end
    // port reset pins; kept through hot reset like unlocked fields
    always_ff @(posedge clk) begin
        if (reset) begin
            // pins float until software enables them
            port_rst_oe <= `SHR_GPIO_OE_RST;
            port_rst_n_o <= `SHR_GPIO_VAL_RST;
        end else if (wr_ok && hit(avs_address, `SHR_GPIO_OFS)) begin
            port_rst_oe <= avs_writedata[`SHR_GPIO_OE_MSB:`SHR_GPIO_OE_LSB];
            port_rst_n_o <= avs_writedata[`SHR_GPIO_VAL_MSB:`SHR_GPIO_VAL_LSB];
        end
    end
    // sequencer next state
    always_comb begin
        state_nxt = seq_state;
        case (seq_state)
            SHR_IDLE: begin
                state_nxt = SHR_IDLE;
            end
            // leave hold only once all triggers gone
            SHR_HOLD: begin
                state_nxt = SHR_QUASI;
            end
            // load only if mode needs it, not disabled
            SHR_QUASI: begin
                state_nxt = (needs_ee(mode_r) && !ctl_eed_r) ? SHR_EELOAD : SHR_IDLE;
            end
            SHR_EELOAD: begin
                if (ee_error) begin
                    state_nxt = SHR_HALT;
                end else if (ee_done) begin
                    state_nxt = SHR_IDLE;
                end
            end
            SHR_HALT: begin
                if (!ctl_halt_r) begin
                    state_nxt = SHR_IDLE;
                end
            end
            default: begin
                state_nxt = SHR_IDLE;
            end
        endcase
        if (hr_cond) begin
            state_nxt = SHR_HOLD;
        end
    end
    // state and reset outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            seq_state <= SHR_IDLE;
            core_reset <= 1'b0;
            stack_quasi_reset <= 1'b0;
            nonsticky_clear <= 1'b0;
        end else begin
            seq_state <= state_nxt;
            // core logic reset in hold; phy and smbus outside it
            core_reset <= (state_nxt == SHR_HOLD) || (state_nxt == SHR_HALT);
            stack_quasi_reset <= (state_nxt == SHR_QUASI) || (state_nxt == SHR_EELOAD)
                || (state_nxt == SHR_HALT);
            // one pulse clears non-sticky fields elsewhere
            nonsticky_clear <= enter_hold;
        end
    end
    // link side pulses and levels
    always_ff @(posedge clk) begin
        if (reset) begin
            ds_hot_reset_ts1 <= '0;
            link_train_start <= 1'b0;
            ds_retrain <= '0;
        end else begin
            // only ports with link up propagate
            ds_hot_reset_ts1 <= hr_cond ? ds_link_up : '0;
            // training starts as the hold ends; no wait after
            link_train_start <= hold_now & ~hr_cond;
            // eeprom retrain writes go to the ports
            ds_retrain <= (seq_state == SHR_EELOAD && ee_retrain_wr) ? ee_retrain_mask : '0;
        end
    end

    // eeprom loader control and config retries
    always_ff @(posedge clk) begin
        if (reset) begin
            ee_start <= 1'b0;
            ee_abort <= 1'b0;
            cfg_retry <= 1'b0;
        end else begin
            ee_start <= (seq_state == SHR_QUASI) && (state_nxt == SHR_EELOAD);
            ee_abort <= (seq_state == SHR_EELOAD) && ee_error && !hr_cond;
            // config requests get retry in quasi reset
            cfg_retry <= cfg_req & stack_quasi_reset;
        end
    end

    // helper: cycles from hold exit until training starts
    always_ff @(posedge clk) begin
        if (reset || hold_now || !pending_r) begin
            wait_cnt_r <= `SHR_ZERO32;
        end else if (wait_cnt_r != 32'hFFFF_FFFF) begin
            wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
        end
    end

    // helper: armed by a hot reset, cleared by training start
    always_ff @(posedge clk) begin
        if (reset || link_train_start) begin
            pending_r <= 1'b0;
        end else if (hold_now) begin
            pending_r <= 1'b1;
        end
    end

    // soft reset write, then one idle cycle, then hold
    sequence sw_write_s;
        wr_ok && hit(avs_address, `SHR_CTL_OFS) && avs_writedata[`SHR_CTL_HR]
            && seq_state == SHR_IDLE && !hr_cond;
    endsequence
    sequence sw_after_s;
        seq_state == SHR_IDLE ##1 seq_state == SHR_HOLD;
    endsequence
    sw_complete_a: assert property (@(posedge clk) disable iff (reset)
        sw_write_s |=> sw_after_s) else $error("soft hot reset not after completion");
    ts1_trig_a: assert property (@(posedge clk) disable iff (reset)
        us_hot_reset_ts1 |=> seq_state == SHR_HOLD) else $error("ts1 did not start hot reset");
    ldd_mask_a: assert property (@(posedge clk) disable iff (reset)
        (seq_state == SHR_IDLE && us_dl_down && ctl_ldd_r && !us_hot_reset_ts1 && !sw_pend_r)
        |=> seq_state == SHR_IDLE) else $error("disabled link down started reset");
    prop_ts1_a: assert property (@(posedge clk) disable iff (reset)
        hr_cond |=> ds_hot_reset_ts1 == $past(ds_link_up)) else $error("hot reset not propagated");
    core_hold_a: assert property (@(posedge clk) disable iff (reset)
        seq_state == SHR_HOLD |-> core_reset && !stack_quasi_reset) else $error("core not in reset");
    train_20ms_a: assert property (@(posedge clk) disable iff (reset)
        pending_r |-> wait_cnt_r < TRAIN_CYC) else $error("training started too late");
    crs_retry_a: assert property (@(posedge clk) disable iff (reset)
        (cfg_req && stack_quasi_reset && wait_cnt_r < CRS_CYC) |=> cfg_retry)
        else $error("config request not retried");
    halt_err_a: assert property (@(posedge clk) disable iff (reset)
        (seq_state == SHR_EELOAD && ee_error && !hr_cond)
        |=> ctl_halt_r && sts_done_r && ee_abort ##1 seq_state == SHR_HALT && core_reset)
        else $error("load error not halted");
    ee_gate_a: assert property (@(posedge clk) disable iff (reset)
        (seq_state == SHR_QUASI && !hr_cond) |=> (seq_state == SHR_EELOAD)
        == (needs_ee(mode_r) && !ctl_eed_r)) else $error("eeprom load decision wrong");
    smb_zero_a: assert property (@(posedge clk) disable iff (reset)
        (avs_read && avs_waitrequest && hold_now) |=> avs_readdata == `SHR_ZERO32)
        else $error("read during hot reset not zero");
endmodule
`default_nettype wire

// file: shr_top_tb.sv
// self-checking bench for the hot reset sequencer
`include "shr_regs.svh"
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected at %0t got %h expected %h", $time, (got), (exp)); end end
module shr_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import shr_pkg::*;
    // clock, reset and register bus
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    // link events, straps and config requests
    logic us_hot_reset_ts1 = 1'b0;
    logic us_dl_down = 1'b0;
    logic [3:0] ds_link_up = 4'h5; // ports 1 and 3 down
    logic [2:0] switch_operating_mode = 3'h0;
    logic cfg_req = 1'b0;
    // design outputs
    logic [3:0] ds_hot_reset_ts1, ds_retrain, port_rst_n_o, port_rst_oe, ee_retrain_mask;
    logic link_train_start, core_reset, stack_quasi_reset, nonsticky_clear, us_sec_bus_reset, cfg_retry;
    logic ee_start, ee_abort, ee_done, ee_error, ee_retrain_wr;
    logic [2:0] ee_error_code;
    shr_state_t seq_state;
    // loader knobs
    logic fail_load = 1'b0;
    logic [2:0] fail_code = 3'h0;
    logic [3:0] retrain_mask = 4'h0;
    logic [3:0] load_len = 4'h3;
    // bookkeeping
    logic [3:0] seen_retrain;
    logic [31:0] rdata;
    int err_total = 0;
    int n_checks = 0;

    always #10 clk = ~clk;

    // retrain pulses are one cycle, so gather them until the next reset
    always @(posedge clk) begin
        seen_retrain <= reset ? 4'h0 : (seen_retrain | ds_retrain);
    end

    // short counts keep the timed assertions within reach
    shr_top #(.TRAIN_CYC(64), .CRS_CYC(128)) shr_top_inst (
        .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .us_hot_reset_ts1(us_hot_reset_ts1), .us_dl_down(us_dl_down),
        .ds_link_up(ds_link_up), .ds_hot_reset_ts1(ds_hot_reset_ts1), .ds_retrain(ds_retrain),
        .link_train_start(link_train_start), .switch_operating_mode(switch_operating_mode),
        .core_reset(core_reset), .stack_quasi_reset(stack_quasi_reset), .nonsticky_clear(nonsticky_clear),
        .us_sec_bus_reset(us_sec_bus_reset), .seq_state(seq_state), .cfg_req(cfg_req), .cfg_retry(cfg_retry),
        .ee_start(ee_start), .ee_abort(ee_abort), .ee_done(ee_done), .ee_error(ee_error),
        .ee_error_code(ee_error_code), .ee_retrain_wr(ee_retrain_wr), .ee_retrain_mask(ee_retrain_mask),
        .port_rst_n_o(port_rst_n_o), .port_rst_oe(port_rst_oe)
    );
    shr_ee_model shr_ee_model_inst (
        .clk(clk), .reset(reset), .ee_start(ee_start), .fail_load(fail_load), .fail_code(fail_code),
        .retrain_mask(retrain_mask), .load_len(load_len), .ee_done(ee_done), .ee_error(ee_error),
        .ee_error_code(ee_error_code), .ee_retrain_wr(ee_retrain_wr), .ee_retrain_mask(ee_retrain_mask)
    );

    // counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // a wait that ran out ends the run
    task automatic hang();
        err_total++;
        $display("unexpected at %0t wait ran out", $time);
        print_verdict();
    endtask
    // fundamental reset, strap sampled while it is high
    task automatic do_reset(input logic [2:0] mode);
        @(posedge clk);
        reset <= 1'b1;
        switch_operating_mode <= mode;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= 4'hF;
        avs_write <= wr;
        avs_read <= !wr;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 20) hang();
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(rdata, exp);
    endtask
    // bounded wait for a sequencer state, sampled mid cycle
    task automatic wait_state(input shr_state_t s, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(negedge clk);
            if (seq_state === s) break;
        end
        if (i == n) hang();
    endtask
    // held trigger, then release and follow the sequence
    task automatic hot_cycle(input logic use_dd, input shr_state_t after);
        @(posedge clk);
        if (use_dd)
            us_dl_down <= 1'b1;
        else
            us_hot_reset_ts1 <= 1'b1;
        wait_state(SHR_HOLD, 4);
        `CHK(nonsticky_clear, 1'b1);
        `CHK(core_reset, 1'b1);
        `CHK(ds_hot_reset_ts1, ds_link_up);
        repeat (3) begin
            @(negedge clk);
            `CHK(seq_state, SHR_HOLD);
        end
        @(posedge clk);
        if (use_dd)
            us_dl_down <= 1'b0;
        else
            us_hot_reset_ts1 <= 1'b0;
        wait_state(SHR_QUASI, 4);
        `CHK(link_train_start, 1'b1);
        `CHK(stack_quasi_reset, 1'b1);
        `CHK(core_reset, 1'b0);
        @(negedge clk);
        `CHK(seq_state, after);
        `CHK(ee_start, after == SHR_EELOAD);
    endtask

    // reset values of the pins and registers
    task automatic t_reset();
        do_reset(3'h0);
        @(negedge clk);
        `CHK(port_rst_oe, 4'h0);
        `CHK(port_rst_n_o, 4'hF);
        `CHK(seq_state, SHR_IDLE);
        rd(`SHR_GPIO_OFS, 32'h0000_00F0);
        rd(5'h14, 32'h0000_0000);
        $display("test reset finished");
    endtask
    // ordered sets, link down, and link down while disabled
    task automatic t_trig();
        hot_cycle(1'b0, SHR_IDLE);
        hot_cycle(1'b1, SHR_IDLE);
        bus(1'b1, `SHR_CTL_OFS, 32'h0000_0002);
        @(posedge clk);
        us_dl_down <= 1'b1;
        repeat (4) begin
            @(negedge clk);
            `CHK(seq_state, SHR_IDLE);
        end
        hot_cycle(1'b0, SHR_IDLE);
        rd(`SHR_CTL_OFS, 32'h0000_0002);
        @(posedge clk);
        us_dl_down <= 1'b0;
        bus(1'b1, `SHR_CTL_OFS, 32'h0000_0000);
        $display("test triggers finished");
    endtask
    // software trigger, field survival, bus access while held
    task automatic t_soft();
        bus(1'b1, `SHR_BRIDGE_OFS, 32'h0000_0001);
        @(negedge clk);
        `CHK(us_sec_bus_reset, 1'b1);
        bus(1'b1, `SHR_GPIO_OFS, 32'h0000_005A);
        bus(1'b1, `SHR_CTL_OFS, 32'h0000_0001);
        @(negedge clk);
        `CHK(seq_state == SHR_HOLD, 1'b0);
        wait_state(SHR_HOLD, 4);
        `CHK(nonsticky_clear, 1'b1);
        wait_state(SHR_IDLE, 8);
        rd(`SHR_BRIDGE_OFS, 32'h0000_0000);
        `CHK(us_sec_bus_reset, 1'b0);
        rd(`SHR_GPIO_OFS, 32'h0000_005A);
        @(posedge clk);
        us_hot_reset_ts1 <= 1'b1;
        rd(`SHR_GPIO_OFS, 32'h0000_0000);
        bus(1'b1, `SHR_GPIO_OFS, 32'h0000_0033);
        @(posedge clk);
        us_hot_reset_ts1 <= 1'b0;
        wait_state(SHR_IDLE, 8);
        rd(`SHR_GPIO_OFS, 32'h0000_005A);
        $display("test software reset finished");
    endtask
    // slow good load, then a fast failing one
    task automatic t_ee();
        do_reset(`SHR_MODE_EE);
        retrain_mask <= 4'h3;
        load_len <= 4'hC;
        hot_cycle(1'b0, SHR_EELOAD);
        @(posedge clk);
        cfg_req <= 1'b1;
        @(posedge clk);
        cfg_req <= 1'b0;
        @(negedge clk);
        `CHK(cfg_retry, 1'b1);
        wait_state(SHR_IDLE, 20);
        `CHK(stack_quasi_reset, 1'b0);
        `CHK(seen_retrain, 4'h3);
        rd(`SHR_STS_OFS, 32'h0000_0001);
        fail_load <= 1'b1;
        fail_code <= 3'h5;
        load_len <= 4'h3;
        hot_cycle(1'b0, SHR_EELOAD);
        wait_state(SHR_HALT, 8);
        `CHK(ee_abort, 1'b1);
        `CHK(core_reset, 1'b1);
        rd(`SHR_CTL_OFS, 32'h0000_0008);
        rd(`SHR_STS_OFS, 32'h0000_000B);
        `CHK(stack_quasi_reset, 1'b1);
        bus(1'b1, `SHR_CTL_OFS, 32'h0000_0000);
        wait_state(SHR_IDLE, 4);
        `CHK(core_reset, 1'b0);
        $display("test eeprom load finished");
    endtask
    // load disabled: no load and no halt even with a bad loader
    task automatic t_dis();
        bus(1'b1, `SHR_CTL_OFS, 32'h0000_0004);
        hot_cycle(1'b0, SHR_IDLE);
        rd(`SHR_CTL_OFS, 32'h0000_0004);
        $display("test load disable finished");
    endtask

    // main sequence
    initial begin
        t_reset();
        t_trig();
        t_soft();
        t_ee();
        t_dis();
        print_verdict();
    end
endmodule
`default_nettype wire
